// file: hw/cvs_map.svh
// constants of the common-voltage setting serial port: bus address, byte
// layout, timing and the controller's own register map.
// assumes inclusion by bare name from every file that needs a number.
`ifndef CVS_MAP_SVH
`define CVS_MAP_SVH

// device bus address, 7 bits (write byte 9e, read byte 9f)
`define CVS_DEV_ADDR        7'h4f
`define CVS_RW_READ         1'h1
`define CVS_DEST_DAC_ONLY   1'h1
`define CVS_BITS_PER_BYTE   4'h8
`define CVS_BIT_DONE_LAST   4'h7
`define CVS_NVM_INIT        7'h40

// timing
`define CVS_LINK_PERIOD_NS  80
`define CVS_NVM_PROG_US     100
`define CVS_CLK_MHZ         200
`define CVS_STD_KBPS        100
`define CVS_FAST_KBPS       400

// controller register map (plain port, byte offsets)
`define CVS_REG_CTRL        4'h0
`define CVS_REG_TXDATA      4'h4
`define CVS_REG_RXDATA      4'h8
`define CVS_REG_STATUS      4'hc
`define CVS_CTRL_GO         0
`define CVS_CTRL_READ       1
`define CVS_CTRL_FAST       2
`define CVS_STAT_BUSY       0
`define CVS_STAT_NACK       1
`define CVS_STAT_DONE       2
`define CVS_FRAME_LOAD_RD   9'h1ff

`endif

// file: hw/cvs_pkg.sv
// types shared by both ends of the common-voltage setting port.
// assumes nothing of its surroundings.
package cvs_pkg;

  typedef enum logic [2:0] {
    DEV_IDLE      = 3'h0,
    DEV_ADDR      = 3'h1,
    DEV_ADDR_ACK  = 3'h2,
    DEV_WDATA     = 3'h3,
    DEV_WDATA_ACK = 3'h4,
    DEV_RDATA     = 3'h5,
    DEV_RDATA_ACK = 3'h6,
    DEV_IGNORE    = 3'h7
  } cvs_dev_state_e;

  typedef enum logic [1:0] {
    HST_IDLE  = 2'h0,
    HST_START = 2'h1,
    HST_BITS  = 2'h2,
    HST_STOP  = 2'h3
  } cvs_hst_state_e;

endpackage

// file: hw/cvs_link_if.sv
// two-wire serial link between the bus master and the setting port.
// assumes open-drain pins; the wired-and level is resolved here.
`timescale 1ns/1ps
`default_nettype none

interface cvs_link_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;

  // pull-up when nobody drives
  assign scl = scl_m_oe ? scl_m_o : 1'h1;
  assign sda = (sda_m_oe ? sda_m_o : 1'h1) & (sda_s_oe ? sda_s_o : 1'h1);

  modport master (
    output scl_m_o,
    output scl_m_oe,
    output sda_m_o,
    output sda_m_oe,
    input  scl,
    input  sda
  );

  modport slave (
    output sda_s_o,
    output sda_s_oe,
    input  scl,
    input  sda
  );
endinterface

`default_nettype wire

// file: hw/cvs_device.sv
// serial slave port holding the 7-bit common-voltage code in a working
// dac copy and a nonvolatile copy, clocked by the link oversampling clock.
// assumes the link clock is well above four times the fastest bus rate.
//
// Overview of operation
// - write byte bits 7..1 carry the code
// - read returns nonvolatile code in bits 7..1
// - write bit0 low updates dac and nonvolatile
// - write bit0 high updates dac only
// - read bit0 high when copies differ
// - write: start, address, ack, data, ack, stop
// - read: start, address, ack, byte, nack, stop
// - slave only, standard and fast rates
// - address ignored while a write completes
// - master never restarts inside an address byte
`timescale 1ns/1ps
`default_nettype none
`include "cvs_map.svh"

module cvs_device #(
  parameter int         NVM_PROG_US    = `CVS_NVM_PROG_US,
  parameter int         LINK_PERIOD_NS = `CVS_LINK_PERIOD_NS,
  parameter logic [6:0] NVM_INIT       = `CVS_NVM_INIT
) (
  input  wire logic       clk_link,
  input  wire logic       rst,
  cvs_link_if.slave       link,
  output logic      [6:0] dac_code,
  output logic      [6:0] nvm_code,
  output logic            nvm_busy,
  output logic            code_differs
);

  // least programming time, rounded up to whole link cycles
  localparam int NVM_PROG_RAW = (NVM_PROG_US * 1000 + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int NVM_PROG_CYC = (NVM_PROG_RAW < 1) ? 1 : NVM_PROG_RAW;
  localparam int BUSY_W       = $clog2(NVM_PROG_CYC + 1);
  localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(NVM_PROG_CYC);
  localparam logic [BUSY_W-1:0] BUSY_ONE  = BUSY_W'(1);

  // pin synchronisers and filtered levels
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic       scl_f;
  logic       sda_f;
  logic       scl_q;
  logic       sda_q;
  logic [2:0] next_scl_sync;
  logic [2:0] next_sda_sync;
  logic       next_scl_f;
  logic       next_sda_f;

  // a level counts only once the second and third stages agree, which
  // also rejects single-sample glitches on slow bus edges
  always_comb begin
    next_scl_sync = {scl_sync[1:0], link.scl};
    next_sda_sync = {sda_sync[1:0], link.sda};
    next_scl_f    = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_f;
    next_sda_f    = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_f;
  end

  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_f    <= 1'h1;
      sda_f    <= 1'h1;
      scl_q    <= 1'h1;
      sda_q    <= 1'h1;
    end else begin
      scl_sync <= next_scl_sync;
      sda_sync <= next_sda_sync;
      scl_f    <= next_scl_f;
      sda_f    <= next_sda_f;
      scl_q    <= scl_f;
      sda_q    <= sda_f;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // start and stop are sda edges while scl stays high
  assign scl_rise  = scl_f & ~scl_q;
  assign scl_fall  = ~scl_f & scl_q;
  assign bus_start = scl_f & scl_q & sda_q & ~sda_f;
  assign bus_stop  = scl_f & scl_q & ~sda_q & sda_f;

  // protocol state
  cvs_pkg::cvs_dev_state_e state;
  cvs_pkg::cvs_dev_state_e next_state;
  logic [3:0]        bitcnt;
  logic [3:0]        next_bitcnt;
  logic [7:0]        shift;
  logic [7:0]        next_shift;
  logic [7:0]        tx;
  logic [7:0]        next_tx;
  logic              drive_low;
  logic              next_drive_low;
  logic              is_read;
  logic              next_is_read;
  logic              sda_out;
  logic [6:0]        next_dac;
  logic [6:0]        next_nvm;
  logic [6:0]        pend;
  logic [6:0]        next_pend;
  logic [BUSY_W-1:0] busy_cnt;
  logic [BUSY_W-1:0] next_busy_cnt;
  logic              next_busy;
  logic              next_differs;
  logic [7:0]        rd_byte;

  always_comb begin
    rd_byte        = {nvm_code, code_differs};
    next_state     = state;
    next_bitcnt    = bitcnt;
    next_shift     = shift;
    next_tx        = tx;
    next_drive_low = drive_low;
    next_is_read   = is_read;
    next_dac       = dac_code;
    next_nvm       = nvm_code;
    next_pend      = pend;
    next_busy_cnt  = busy_cnt;
    next_busy      = nvm_busy;

    // nonvolatile programming runs on its own, independent of the bus
    if (busy_cnt != '0) begin
      next_busy_cnt = busy_cnt - BUSY_ONE;
      if (busy_cnt == BUSY_ONE) begin
        next_nvm  = pend;
        next_busy = 1'h0;
      end
    end

    if (bus_stop) begin
      next_state     = cvs_pkg::DEV_IDLE;
      next_drive_low = 1'h0;
    end else if (bus_start) begin
      // a start anywhere resyncs to the address byte
      next_state     = cvs_pkg::DEV_ADDR;
      next_bitcnt    = 4'h0;
      next_drive_low = 1'h0;
    end else begin
      unique case (state)
        cvs_pkg::DEV_IDLE, cvs_pkg::DEV_IGNORE: begin
        end
        cvs_pkg::DEV_ADDR: begin
          if (scl_rise) begin
            next_shift  = {shift[6:0], sda_f};
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == `CVS_BITS_PER_BYTE) begin
            // no acknowledge while programming is still under way
            if (shift[7:1] == `CVS_DEV_ADDR && !nvm_busy) begin
              next_drive_low = 1'h1;
              next_is_read   = (shift[0] == `CVS_RW_READ);
              next_state     = cvs_pkg::DEV_ADDR_ACK;
            end else begin
              next_state = cvs_pkg::DEV_IGNORE;
            end
          end
        end
        cvs_pkg::DEV_ADDR_ACK: begin
          if (scl_fall) begin
            next_bitcnt = 4'h0;
            if (is_read) begin
              next_tx        = rd_byte;
              next_drive_low = ~rd_byte[7];
              next_state     = cvs_pkg::DEV_RDATA;
            end else begin
              next_drive_low = 1'h0;
              next_state     = cvs_pkg::DEV_WDATA;
            end
          end
        end
        cvs_pkg::DEV_WDATA: begin
          if (scl_rise) begin
            next_shift  = {shift[6:0], sda_f};
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == `CVS_BITS_PER_BYTE) begin
            next_drive_low = 1'h1;
            next_state     = cvs_pkg::DEV_WDATA_ACK;
          end
        end
        cvs_pkg::DEV_WDATA_ACK: begin
          if (scl_fall) begin
            next_drive_low = 1'h0;
            next_dac       = shift[7:1];
            if (shift[0] != `CVS_DEST_DAC_ONLY) begin
              next_pend     = shift[7:1];
              next_busy     = 1'h1;
              next_busy_cnt = BUSY_LOAD;
            end
            // a single data byte; anything more is not acknowledged
            next_state = cvs_pkg::DEV_IGNORE;
          end
        end
        cvs_pkg::DEV_RDATA: begin
          if (scl_fall) begin
            next_bitcnt = bitcnt + 4'h1;
            if (bitcnt == `CVS_BIT_DONE_LAST) begin
              next_drive_low = 1'h0;
              next_state     = cvs_pkg::DEV_RDATA_ACK;
            end else begin
              next_tx        = {tx[6:0], 1'h1};
              next_drive_low = ~tx[6];
            end
          end
        end
        cvs_pkg::DEV_RDATA_ACK: begin
          // master answers not-acknowledge; one byte only either way
          if (scl_rise) begin
            next_state = cvs_pkg::DEV_IGNORE;
          end
        end
      endcase
    end

    next_differs = (next_dac != next_nvm);
  end

  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      state        <= cvs_pkg::DEV_IDLE;
      bitcnt       <= 4'h0;
      shift        <= 8'h00;
      tx           <= 8'hff;
      drive_low    <= 1'h0;
      is_read      <= 1'h0;
      sda_out      <= 1'h0;
      dac_code     <= NVM_INIT;
      nvm_code     <= NVM_INIT;
      pend         <= NVM_INIT;
      busy_cnt     <= '0;
      nvm_busy     <= 1'h0;
      code_differs <= 1'h0;
    end else begin
      state        <= next_state;
      bitcnt       <= next_bitcnt;
      shift        <= next_shift;
      tx           <= next_tx;
      drive_low    <= next_drive_low;
      is_read      <= next_is_read;
      sda_out      <= 1'h0;
      dac_code     <= next_dac;
      nvm_code     <= next_nvm;
      pend         <= next_pend;
      busy_cnt     <= next_busy_cnt;
      nvm_busy     <= next_busy;
      code_differs <= next_differs;
    end
  end

  // open drain: only ever pulls low
  assign link.sda_s_o  = sda_out;
  assign link.sda_s_oe = drive_low;

endmodule

`default_nettype wire

// file: hw/cvs_host.sv
// bus master for the common-voltage setting port, ordered through a
// small register port; derives the bus clock from clk_sys by a divider.
// assumes the slave never stretches the clock.
`timescale 1ns/1ps
`default_nettype none
`include "cvs_map.svh"

module cvs_host #(
  parameter int CLK_MHZ   = `CVS_CLK_MHZ,
  parameter int STD_KBPS  = `CVS_STD_KBPS,
  parameter int FAST_KBPS = `CVS_FAST_KBPS
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  cvs_link_if.master      link,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata
);

  // quarter bit period, rounded up so the rate never exceeds its figure
  localparam int QTR_STD  = (CLK_MHZ * 1000 + 4 * STD_KBPS - 1) / (4 * STD_KBPS);
  localparam int QTR_FAST = (CLK_MHZ * 1000 + 4 * FAST_KBPS - 1) / (4 * FAST_KBPS);
  localparam int QW       = $clog2(QTR_STD + 1);
  localparam logic [QW-1:0] QLD_STD  = QW'(QTR_STD - 1);
  localparam logic [QW-1:0] QLD_FAST = QW'(QTR_FAST - 1);

  logic [2:0] sda_sync;
  logic       sda_f;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sda_sync <= 3'h7;
      sda_f    <= 1'h1;
    end else begin
      sda_sync <= {sda_sync[1:0], link.sda};
      sda_f    <= (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_f;
    end
  end

  cvs_pkg::cvs_hst_state_e state;
  cvs_pkg::cvs_hst_state_e next_state;
  logic          fast, next_fast;
  logic          rd_mode, next_rd_mode;
  logic [7:0]    tx_byte, next_tx_byte;
  logic [7:0]    rx_byte, next_rx_byte;
  logic          nack, next_nack;
  logic          done, next_done;
  logic [QW-1:0] qcnt, next_qcnt;
  logic [1:0]    phase, next_phase;
  logic [3:0]    bitcnt, next_bitcnt;
  logic          frame, next_frame;
  logic [8:0]    out_sh, next_out_sh;
  logic [8:0]    in_sh, next_in_sh;
  logic          scl_lo, next_scl_lo;
  logic          sda_lo, next_sda_lo;
  logic [7:0]    next_rdata;
  logic          go;

  assign go = reg_wr && reg_addr == `CVS_REG_CTRL && reg_wdata[`CVS_CTRL_GO];

  always_comb begin
    next_state   = state;
    next_fast    = fast;
    next_rd_mode = rd_mode;
    next_tx_byte = tx_byte;
    next_rx_byte = rx_byte;
    next_nack    = nack;
    next_done    = done;
    next_qcnt    = qcnt;
    next_phase   = phase;
    next_bitcnt  = bitcnt;
    next_frame   = frame;
    next_out_sh  = out_sh;
    next_in_sh   = in_sh;
    next_scl_lo  = scl_lo;
    next_sda_lo  = sda_lo;
    next_rdata   = 8'h00;

    if (reg_wr && reg_addr == `CVS_REG_TXDATA) begin
      next_tx_byte = reg_wdata;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `CVS_REG_CTRL:   next_rdata = {5'h00, fast, rd_mode, 1'h0};
        `CVS_REG_TXDATA: next_rdata = tx_byte;
        `CVS_REG_RXDATA: next_rdata = rx_byte;
        `CVS_REG_STATUS: next_rdata = {5'h00, done, nack, state != cvs_pkg::HST_IDLE};
        default:         next_rdata = 8'h00;
      endcase
    end

    if (state == cvs_pkg::HST_IDLE) begin
      // a new start only from idle, never inside an address byte
      if (go) begin
        next_fast    = reg_wdata[`CVS_CTRL_FAST];
        next_rd_mode = reg_wdata[`CVS_CTRL_READ];
        next_qcnt    = reg_wdata[`CVS_CTRL_FAST] ? QLD_FAST : QLD_STD;
        next_phase   = 2'h0;
        next_bitcnt  = 4'h0;
        next_frame   = 1'h0;
        next_nack    = 1'h0;
        next_done    = 1'h0;
        next_out_sh  = {`CVS_DEV_ADDR, reg_wdata[`CVS_CTRL_READ], 1'h1};
        next_state   = cvs_pkg::HST_START;
      end
    end else if (qcnt != '0) begin
      next_qcnt = qcnt - QW'(1);
    end else begin
      next_qcnt  = fast ? QLD_FAST : QLD_STD;
      next_phase = phase + 2'h1;
      unique case (state)
        cvs_pkg::HST_START: begin
          if (phase == 2'h0) begin
            next_sda_lo = 1'h1;
          end else begin
            next_scl_lo = 1'h1;
            next_phase  = 2'h0;
            next_state  = cvs_pkg::HST_BITS;
          end
        end
        cvs_pkg::HST_BITS: begin
          unique case (phase)
            2'h0: next_sda_lo = ~out_sh[8];
            2'h1: next_scl_lo = 1'h0;
            2'h2: next_in_sh  = {in_sh[7:0], sda_f};
            2'h3: begin
              next_scl_lo = 1'h1;
              next_out_sh = {out_sh[7:0], 1'h1};
              next_bitcnt = bitcnt + 4'h1;
              if (bitcnt == `CVS_BITS_PER_BYTE) begin
                next_bitcnt = 4'h0;
                if (!frame && in_sh[0]) begin
                  next_nack  = 1'h1;
                  next_state = cvs_pkg::HST_STOP;
                end else if (!frame) begin
                  // one data byte; master releases all nine bits when reading
                  next_frame  = 1'h1;
                  next_out_sh = rd_mode ? `CVS_FRAME_LOAD_RD : {tx_byte, 1'h1};
                end else begin
                  if (rd_mode) begin
                    next_rx_byte = in_sh[8:1];
                  end else begin
                    next_nack = in_sh[0];
                  end
                  next_state = cvs_pkg::HST_STOP;
                end
              end
            end
          endcase
        end
        cvs_pkg::HST_STOP: begin
          if (phase == 2'h0) begin
            next_sda_lo = 1'h1;
          end else if (phase == 2'h1) begin
            next_scl_lo = 1'h0;
          end else begin
            next_sda_lo = 1'h0;
            next_done   = 1'h1;
            next_phase  = 2'h0;
            next_state  = cvs_pkg::HST_IDLE;
          end
        end
        default: begin
          next_state = cvs_pkg::HST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state     <= cvs_pkg::HST_IDLE;
      fast      <= 1'h0;
      rd_mode   <= 1'h0;
      tx_byte   <= 8'h00;
      rx_byte   <= 8'h00;
      nack      <= 1'h0;
      done      <= 1'h0;
      qcnt      <= '0;
      phase     <= 2'h0;
      bitcnt    <= 4'h0;
      frame     <= 1'h0;
      out_sh    <= 9'h1ff;
      in_sh     <= 9'h000;
      scl_lo    <= 1'h0;
      sda_lo    <= 1'h0;
      reg_rdata <= 8'h00;
    end else begin
      state     <= next_state;
      fast      <= next_fast;
      rd_mode   <= next_rd_mode;
      tx_byte   <= next_tx_byte;
      rx_byte   <= next_rx_byte;
      nack      <= next_nack;
      done      <= next_done;
      qcnt      <= next_qcnt;
      phase     <= next_phase;
      bitcnt    <= next_bitcnt;
      frame     <= next_frame;
      out_sh    <= next_out_sh;
      in_sh     <= next_in_sh;
      scl_lo    <= next_scl_lo;
      sda_lo    <= next_sda_lo;
      reg_rdata <= next_rdata;
    end
  end

  assign link.scl_m_o  = 1'h0;
  assign link.scl_m_oe = scl_lo;
  assign link.sda_m_o  = 1'h0;
  assign link.sda_m_oe = sda_lo;

endmodule

`default_nettype wire

// file: verification/cvs_link_monitor.sv
// assertions on the two-wire link and the two setting copies.
// assumes instantiation beside the link interface, all on clk_link.
`timescale 1ns/1ps
`default_nettype none

module cvs_link_monitor #(
  parameter int PROG_CYC = 500
) (
  input wire logic       clk_link,
  input wire logic       rst,
  input wire logic       scl,
  input wire logic       sda,
  input wire logic       sda_s_oe,
  input wire logic [6:0] dac_code,
  input wire logic [6:0] nvm_code,
  input wire logic       nvm_busy,
  input wire logic       code_differs
);
  logic        scl_q;
  logic        sda_q;
  logic        in_frame;
  logic        next_in_frame;
  logic [15:0] busy_cnt;
  logic [15:0] next_busy_cnt;
  logic        bus_start;
  logic        bus_stop;

  assign bus_start = scl && scl_q && sda_q && !sda;
  assign bus_stop  = scl && scl_q && !sda_q && sda;

  always_comb begin
    next_in_frame = in_frame;
    if (bus_start) begin
      next_in_frame = 1'b1;
    end else if (bus_stop) begin
      next_in_frame = 1'b0;
    end
    next_busy_cnt = nvm_busy ? busy_cnt + 16'h0001 : 16'h0000;
  end

  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      in_frame <= 1'b0;
      busy_cnt <= 16'h0000;
    end else begin
      scl_q    <= scl;
      sda_q    <= sda;
      in_frame <= next_in_frame;
      busy_cnt <= next_busy_cnt;
    end
  end

  default clocking cb @(posedge clk_link); endclocking
  default disable iff (rst);

  a_flag_tracks_copies: assert property (
    code_differs == (dac_code != nvm_code))
    else $error("difference flag out of step with the copies");
  a_nvm_change_timing: assert property (
    $changed(nvm_code) |-> !nvm_busy && ($past(nvm_busy) || $past(nvm_busy, 2)))
    else $error("nonvolatile copy changed outside a programming end");
  a_nvm_gets_dac: assert property (
    $fell(nvm_busy) |-> ##[0:1] nvm_code == dac_code)
    else $error("nonvolatile copy differs from working copy after programming");
  a_busy_length: assert property (
    $fell(nvm_busy) |-> busy_cnt >= PROG_CYC - 2 && busy_cnt <= PROG_CYC + 2)
    else $error("programming window of wrong length");
  a_dac_frozen_busy: assert property (
    nvm_busy && $past(nvm_busy) |-> $stable(dac_code))
    else $error("working copy changed while programming");
  a_no_ack_busy: assert property (
    nvm_busy && $past(nvm_busy, 4) |-> !sda_s_oe)
    else $error("device drove the data line while programming");
  a_sda_moves_low: assert property (
    $changed(sda_s_oe) |-> !scl)
    else $error("device changed the data line while the clock was high");
  a_start_outside_frame: assert property (
    bus_start |-> !in_frame)
    else $error("start inside an unfinished frame");

  c_programming: cover property ($rose(nvm_busy));
  c_differs: cover property ($rose(code_differs));
  c_device_drives: cover property ($rose(sda_s_oe));
endmodule

`default_nettype wire

// file: verification/common_voltage_code_setting_serial_port_tb.sv
// bench joining the host and the device over the link interface.
// assumes the host register map and timing of the design constants.
`timescale 1ns/1ps
`default_nettype none
`include "cvs_map.svh"

`define TB_EQ(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("ERROR %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module common_voltage_code_setting_serial_port_tb;
  // long enough that a read issued at once still meets the busy window
  localparam int PROG_US  = 40;
  localparam int PROG_CYC = PROG_US * 1000 / `CVS_LINK_PERIOD_NS;

  logic        clk_sys;
  logic        clk_link;
  logic        rst;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [6:0]  dac_code;
  logic [6:0]  nvm_code;
  logic        nvm_busy;
  logic        code_differs;
  logic [18:0] wire_bits;
  int          bad_count;
  int          tests_run;

  cvs_link_if lnk ();

  cvs_host i_cvs_host (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .link      (lnk),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata)
  );

  cvs_device #(.NVM_PROG_US(PROG_US)) i_cvs_device (
    .clk_link     (clk_link),
    .rst          (rst),
    .link         (lnk),
    .dac_code     (dac_code),
    .nvm_code     (nvm_code),
    .nvm_busy     (nvm_busy),
    .code_differs (code_differs)
  );

  cvs_link_monitor #(.PROG_CYC(PROG_CYC)) i_cvs_link_monitor (
    .clk_link     (clk_link),
    .rst          (rst),
    .scl          (lnk.scl),
    .sda          (lnk.sda),
    .sda_s_oe     (lnk.sda_s_oe),
    .dac_code     (dac_code),
    .nvm_code     (nvm_code),
    .nvm_busy     (nvm_busy),
    .code_differs (code_differs)
  );

  always #2.5 clk_sys = ~clk_sys;

  // first rising edge lands inside reset, so sampled history starts clean
  initial begin
    clk_link = 1'b0;
    #7;
    clk_link = 1'b1;
    forever #40 clk_link = ~clk_link;
  end

  // wire log: every bit seen at a clock rise since the last start
  always @(negedge lnk.sda) begin
    if (lnk.scl === 1'b1) begin
      wire_bits = '0;
    end
  end

  always @(posedge lnk.scl) begin
    wire_bits = {wire_bits[17:0], lnk.sda};
  end

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic give_up();
    bad_count++;
    $display("ERROR %0t: wait ran out", $time);
    results();
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic run_xfer(input logic [7:0] ctrl, input logic [7:0] tx, input logic nack);
    logic [7:0] st;
    int         n;
    st = 8'h00;
    reg_write(`CVS_REG_TXDATA, tx);
    reg_write(`CVS_REG_CTRL, ctrl);
    for (n = 0; n < 40000 && st[`CVS_STAT_DONE] !== 1'b1; n++) begin
      reg_read(`CVS_REG_STATUS, st);
    end
    if (st[`CVS_STAT_DONE] !== 1'b1) begin
      give_up();
    end
    `TB_EQ(st[`CVS_STAT_NACK], nack)
  endtask

  task automatic check_reset();
    logic [7:0] d;
    logic [3:0] ro_list [4];
    ro_list = '{`CVS_REG_CTRL, `CVS_REG_RXDATA, `CVS_REG_STATUS, 4'h2};
    foreach (ro_list[i]) begin
      reg_read(ro_list[i], d);
      `TB_EQ(d, 8'h00)
    end
    reg_write(`CVS_REG_TXDATA, 8'ha5);
    reg_read(`CVS_REG_TXDATA, d);
    `TB_EQ(d, 8'ha5)
    `TB_EQ(dac_code, `CVS_NVM_INIT)
    `TB_EQ(code_differs, 1'b0)
  endtask

  task automatic dac_only_write();
    run_xfer(8'h05, {7'h77, `CVS_DEST_DAC_ONLY}, 1'b0);
    `TB_EQ(wire_bits, {`CVS_DEV_ADDR, 1'b0, 1'b0, 7'h77, 1'b1, 1'b0, 1'b0})
    `TB_EQ(dac_code, 7'h77)
    `TB_EQ(nvm_code, `CVS_NVM_INIT)
    `TB_EQ(code_differs, 1'b1)
  endtask

  task automatic read_flagged();
    logic [7:0] d;
    run_xfer(8'h07, 8'h00, 1'b0);
    reg_read(`CVS_REG_CTRL, d);
    `TB_EQ(d, {5'h00, 1'b1, 1'b1, 1'b0})
    reg_read(`CVS_REG_RXDATA, d);
    `TB_EQ(d, {`CVS_NVM_INIT, 1'b1})
    `TB_EQ(wire_bits, {`CVS_DEV_ADDR, `CVS_RW_READ, 1'b0, `CVS_NVM_INIT, 3'b110})
  endtask

  task automatic both_write_busy();
    int n;
    run_xfer(8'h05, {7'h2c, 1'b0}, 1'b0);
    `TB_EQ(dac_code, 7'h2c)
    `TB_EQ(nvm_busy, 1'b1)
    // a read issued at once must find the device deaf
    run_xfer(8'h07, 8'h00, 1'b1);
    `TB_EQ(wire_bits[9:0], {`CVS_DEV_ADDR, `CVS_RW_READ, 2'b10})
    for (n = 0; n < 20000 && nvm_busy !== 1'b0; n++) begin
      @(posedge clk_sys);
    end
    if (nvm_busy !== 1'b0) begin
      give_up();
    end
    repeat (2) @(posedge clk_link);
    #1;
    `TB_EQ(nvm_code, 7'h2c)
    `TB_EQ(code_differs, 1'b0)
  endtask

  task automatic std_rate_read();
    logic [7:0] d;
    run_xfer(8'h03, 8'h00, 1'b0);
    reg_read(`CVS_REG_RXDATA, d);
    `TB_EQ(d, {7'h2c, 1'b0})
    `TB_EQ(dac_code, 7'h2c)
  endtask

  initial begin
    clk_sys   = 1'b0;
    rst       = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    wire_bits = '0;
    bad_count = 0;
    tests_run = 0;
    // a clean rising edge so every asynchronous reset surely fires
    #1;
    rst       = 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    // the device wants a few link cycles before the first start
    repeat (80) @(posedge clk_sys);
    check_reset();
    dac_only_write();
    read_flagged();
    both_write_busy();
    std_rate_read();
    results();
  end
endmodule

`default_nettype wire
